// ===== ubsa_device_end.sv
`timescale 1ns/1ps
// Overview of operation
// - Five-bit prescale code, zero stops clock
// - Async bit rate is Fc/(16*N*P)
// - Divisor field holds N-1, divides by N
// - Sync mode uses factor two not sixteen
// - Async rates up to about 987.5k
// - Low power sets empty flag, clears status
// - Buffers kept, transmit shifter forced ones
// - Start bit on receive pin wakes device
// - Software enables wakeup bit 3, low level
// - Crystal wake waits 256 core clocks
// - Both length bits loop transmit to receive
// - Loopback frame is nine data bits
// - Hunting bit enabled with nine-bit frame
// - Ninth bit one means address character
// - Hunting drops data, address sets full flag
// - Accepted address clears hunting bit
// - Transmitter unchanged; ninth bits via controls
// - Bit access to receive control clears errors
// - Eleven-bit divisor, prescale register resets zero
// - Stop clock before changing bit rate
module ubsa_device_end (
  input wire logic core_clk_i,
  input wire logic reset_i,
  ubsa_link_if.device link,
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic xtal_i,
  output logic low_power_o,
  output logic run_o,
  output logic tick_o
);
  import ubsa_pkg::*;
  typedef struct packed {
    logic [7:0] prescaler_select_reg;
    logic [7:0] baud;
    logic [7:0] line;
    logic [7:0] rxcs;
    logic [7:0] txbuf;
    logic [7:0] rxbuf;
    logic [7:0] wake;
    logic lp;
    logic [8:0] settle;
    logic run;
    logic [4:0] pcnt;
    logic half;
    logic [DIV_W-1:0] dcnt;
    logic tick;
    logic [3:0] ttick;
    logic [10:0] tsh;
    logic [3:0] tbits;
    logic tbusy;
    logic [1:0] sync;
    logic rbusy;
    logic [3:0] rtick;
    logic [3:0] rbits;
    logic [9:0] rsh;
    logic [7:0] rdata;
    logic [7:0] rdo;
  } ubsa_dev_t;
  ubsa_dev_t s_reg, s_next;
  logic [4:0] psel;
  logic [DIV_W-1:0] div_nm1;
  logic [4:0] p_len;
  logic pre_tick;
  logic loop;
  logic rx_in;
  logic [3:0] os_last;
  assign psel = s_reg.prescaler_select_reg[PSR_SEL_LSB +: 5];
  assign div_nm1 = {s_reg.prescaler_select_reg[PSR_DIVHI_LSB +: 3], s_reg.baud};
  assign loop = s_reg.line[LC_CHL0] & s_reg.line[LC_CHL1];
  // Sync mode: two ticks per bit instead of sixteen
  assign os_last = s_reg.line[LC_SYNC] ? 4'h1 : 4'hf;
  // Code k gives factor (k+1)/2: period floor or ceil alternately
  assign p_len = s_reg.half ? (psel >> 1) : (psel >> 1) + 5'h1;
  assign pre_tick = (psel != PSC_OFF) && (s_reg.pcnt + 5'h1 >= p_len);
  // Loopback feeds receiver from transmit shifter, not the pin
  assign rx_in = loop ? s_reg.tsh[0] : s_reg.sync[1];
  always_comb begin
    s_next = s_reg;
    s_next.tick = 1'b0;
    s_next.sync = {s_reg.sync[0], link.far_tx};
    // Prescaler; code zero holds the chain still
    if (psel == PSC_OFF) begin
      s_next.pcnt = 5'h0;
      s_next.dcnt = div_nm1;
      s_next.half = 1'b0;
    end else if (pre_tick) begin
      s_next.pcnt = 5'h0;
      s_next.half = psel[0] ? 1'b0 : ~s_reg.half;
      if (s_reg.dcnt == '0) begin
        s_next.dcnt = div_nm1;
        s_next.tick = 1'b1;
      end else begin
        s_next.dcnt = s_reg.dcnt - 1'b1;
      end
    end else begin
      s_next.pcnt = s_reg.pcnt + 5'h1;
    end
    // Transmitter, same framing whether hunting or not
    if (s_reg.tick && s_reg.run) begin
      s_next.ttick = s_reg.ttick + 4'h1;
      if (!s_reg.tbusy && !s_reg.line[LC_TX_BUFFER_EMPTY_FLAG]) begin
        s_next.tsh = {1'b1, s_reg.line[LC_TX_NINTH_BIT], s_reg.txbuf, 1'b0};
        s_next.tbusy = 1'b1;
        s_next.tbits = 4'h0;
        s_next.ttick = 4'h0;
        s_next.line[LC_TX_BUFFER_EMPTY_FLAG] = 1'b1;
      end else if (s_reg.tbusy && s_reg.ttick == os_last) begin
        s_next.ttick = 4'h0;
        s_next.tsh = {1'b1, s_reg.tsh[10:1]};
        s_next.tbits = s_reg.tbits + 4'h1;
        if (s_reg.tbits == (s_reg.line[LC_STOP2] ? 4'hb : 4'ha)) begin
          s_next.tbusy = 1'b0;
        end
      end
    end
    // Receiver, mid-bit sampling
    if (s_reg.tick && s_reg.run) begin
      if (!s_reg.rbusy) begin
        if (!rx_in) begin
          s_next.rbusy = 1'b1;
          s_next.rtick = 4'h0;
          s_next.rbits = 4'h0;
        end
      end else begin
        s_next.rtick = s_reg.rtick + 4'h1;
        if (s_reg.rtick == (os_last >> 1)) begin
          s_next.rsh = {rx_in, s_reg.rsh[9:1]};
          s_next.rbits = s_reg.rbits + 4'h1;
          if (s_reg.rbits == 4'h0 && rx_in) begin
            s_next.rbusy = 1'b0;
          end
          if (s_reg.rbits == 4'ha) begin
            s_next.rbusy = 1'b0;
            s_next.rxcs[RX_FERR] = s_reg.rxcs[RX_FERR] | ~rx_in;
            // Address iff ninth bit set
            if (!s_reg.rxcs[RX_ADDRESS_HUNT_BIT] || s_reg.rsh[9]) begin
              s_next.rdata = s_reg.rsh[8:1];
              s_next.rxcs[RX_RX_NINTH_BIT] = s_reg.rsh[9];
              s_next.rxcs[RX_OERR] = s_reg.rxcs[RX_OERR]
                | s_reg.rxcs[RX_RX_BUFFER_FULL_FLAG];
              s_next.rxcs[RX_RX_BUFFER_FULL_FLAG] = 1'b1;
              s_next.rxcs[RX_ADDRESS_HUNT_BIT] = 1'b0;
            end
          end
        end else if (s_reg.rtick == os_last) begin
          s_next.rtick = 4'h0;
        end
      end
    end
    // Software port; hardware set outranks its clear for the receive full flag only
    if (wr_i) begin
      case (addr_i)
        ADDR_PSR: s_next.prescaler_select_reg = wdata_i;
        ADDR_BAUD: s_next.baud = wdata_i;
        ADDR_LINE: s_next.line[4:0] = wdata_i[4:0];
        ADDR_RXCS: begin
          s_next.rxcs[RX_ADDRESS_HUNT_BIT] = wdata_i[RX_ADDRESS_HUNT_BIT];
          if (wdata_i[RX_BITOP]) begin
            s_next.rxcs[RX_FERR] = 1'b0;
            s_next.rxcs[RX_OERR] = 1'b0;
          end
        end
        ADDR_TXBUF: begin
          s_next.txbuf = wdata_i;
          s_next.line[LC_TX_BUFFER_EMPTY_FLAG] = 1'b0;
        end
        ADDR_PWR: s_next.lp = wdata_i[0];
        ADDR_WAKE: s_next.wake = wdata_i;
        default: s_next.lp = s_next.lp;
      endcase
    end
    if (rd_i && addr_i == ADDR_RXBUF && !s_next.rxcs[RX_RX_BUFFER_FULL_FLAG]) begin
      s_next.rdata = s_reg.rdata;
    end
    if (rd_i && addr_i == ADDR_RXBUF && !(s_reg.tick && s_reg.rbusy
        && s_reg.rbits == 4'ha)) begin
      s_next.rxcs[RX_RX_BUFFER_FULL_FLAG] = 1'b0;
    end
    s_next.rxbuf = s_next.rdata;
    // Read data stands one cycle, zero otherwise
    s_next.rdo = 8'h00;
    if (rd_i) begin
      case (addr_i)
        ADDR_PSR: s_next.rdo = s_reg.prescaler_select_reg;
        ADDR_BAUD: s_next.rdo = s_reg.baud;
        ADDR_LINE: s_next.rdo = s_reg.line;
        ADDR_RXCS: s_next.rdo = s_reg.rxcs;
        ADDR_TXBUF: s_next.rdo = s_reg.txbuf;
        ADDR_RXBUF: s_next.rdo = s_reg.rxbuf;
        ADDR_PWR: s_next.rdo = {7'h00, s_reg.lp};
        ADDR_WAKE: s_next.rdo = s_reg.wake;
        default: s_next.rdo = 8'h00;
      endcase
    end
    // Low-power entry reinitialises the serial logic
    if (s_next.lp && !s_reg.lp) begin
      s_next.line[LC_TX_BUFFER_EMPTY_FLAG] = 1'b1;
      s_next.rxcs[RX_FERR] = 1'b0;
      s_next.rxcs[RX_OERR] = 1'b0;
      s_next.rxcs[RX_RX_NINTH_BIT] = 1'b0;
      s_next.rxcs[RX_RX_BUFFER_FULL_FLAG] = 1'b0;
      s_next.tsh = '1;
      s_next.tbusy = 1'b0;
      s_next.rbusy = 1'b0;
      s_next.run = 1'b0;
    end
    // Low level on receive pin wakes, if enabled
    if (s_reg.lp && s_reg.wake[WAKE_RX_BIT] && !s_reg.sync[1]) begin
      s_next.lp = 1'b0;
      s_next.settle = xtal_i ? OSC_SETTLE_LOAD : 9'h000;
    end
    if (!s_reg.lp && !s_reg.run) begin
      if (s_reg.settle == 9'h000) begin
        s_next.run = 1'b1;
      end else begin
        s_next.settle = s_reg.settle - 9'h001;
      end
    end
  end
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      s_reg <= '0;
      s_reg.prescaler_select_reg <= PSR_RESET;
      s_reg.line <= LINE_RESET;
      s_reg.tsh <= '1;
      s_reg.sync <= 2'b11;
      s_reg.run <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end
  assign rdata_o = s_reg.rdo;
  assign link.dev_tx = s_reg.tsh[0];
  assign low_power_o = s_reg.lp;
  assign run_o = s_reg.run;
  assign tick_o = s_reg.tick;
endmodule

// ===== ubsa_pkg.sv
package ubsa_pkg;
  // Register indices on the software port
  localparam logic [3:0] ADDR_PSR = 4'h0;
  localparam logic [3:0] ADDR_BAUD = 4'h1;
  localparam logic [3:0] ADDR_LINE = 4'h2;
  localparam logic [3:0] ADDR_RXCS = 4'h3;
  localparam logic [3:0] ADDR_TXBUF = 4'h4;
  localparam logic [3:0] ADDR_RXBUF = 4'h5;
  localparam logic [3:0] ADDR_PWR = 4'h6;
  localparam logic [3:0] ADDR_WAKE = 4'h7;
  // Prescaler select register layout
  localparam int PSR_SEL_LSB = 3;
  localparam int PSR_DIVHI_LSB = 0;
  localparam logic [7:0] PSR_RESET = 8'h00;
  localparam logic [7:0] LINE_RESET = 8'h20;
  localparam logic [4:0] PSC_OFF = 5'h00;
  localparam int DIV_W = 11;
  // Line control bits
  localparam int LC_CHL0 = 0;
  localparam int LC_CHL1 = 1;
  localparam int LC_TX_NINTH_BIT = 2;
  localparam int LC_SYNC = 3;
  localparam int LC_STOP2 = 4;
  localparam int LC_TX_BUFFER_EMPTY_FLAG = 5;
  // Receive control/status bits
  localparam int RX_ADDRESS_HUNT_BIT = 0;
  localparam int RX_FERR = 1;
  localparam int RX_OERR = 2;
  localparam int RX_RX_NINTH_BIT = 3;
  localparam int RX_RX_BUFFER_FULL_FLAG = 4;
  localparam int RX_BITOP = 7;
  // Wakeup
  localparam int WAKE_RX_BIT = 3;
  // Timing
  localparam int OVERSAMPLE_ASYNC = 16;
  localparam int OVERSAMPLE_SYNC = 2;
  localparam int FRAME_DATA_BITS = 9;
  localparam real MAX_ASYNC_BAUD_K = 987.5;
  localparam int OSC_SETTLE_CYC = 256;
  localparam logic [8:0] OSC_SETTLE_LOAD = 9'h0ff;
endpackage

// ===== ubsa_link_if.sv
`timescale 1ns/1ps
interface ubsa_link_if;
  logic dev_tx;
  logic far_tx;
  modport device (output dev_tx, input far_tx);
  modport far (input dev_tx, output far_tx);
endinterface

// ===== ubsa_far_end.sv
`timescale 1ns/1ps
// Far processor: fixed 9-bit frames, bit_cycles_i core clocks per bit
module ubsa_far_end (
  input wire logic core_clk_i,
  input wire logic reset_i,
  ubsa_link_if.far link,
  input wire logic [15:0] bit_cycles_i,
  input wire logic send_i,
  input wire logic [8:0] send_data_i,
  output logic busy_o,
  output logic rx_valid_o,
  output logic [8:0] rx_data_o
);
  import ubsa_pkg::*;
  typedef struct packed {
    logic [10:0] tsh;
    logic [3:0] tcnt;
    logic [15:0] tdiv;
    logic tbusy;
    logic [1:0] sync;
    logic [9:0] rsh;
    logic [3:0] rcnt;
    logic [15:0] rdiv;
    logic rbusy;
    logic rvalid;
    logic [8:0] rdata;
  } ubsa_far_t;
  ubsa_far_t s_reg, s_next;
  always_comb begin
    s_next = s_reg;
    s_next.rvalid = 1'b0;
    s_next.sync = {s_reg.sync[0], link.dev_tx};
    if (!s_reg.tbusy) begin
      if (send_i) begin
        // Ninth bit: 1 marks an address
        s_next.tsh = {1'b1, send_data_i, 1'b0};
        s_next.tbusy = 1'b1;
        s_next.tcnt = 4'h0;
        s_next.tdiv = 16'h0000;
      end
    end else if (s_reg.tdiv + 16'h0001 >= bit_cycles_i) begin
      s_next.tdiv = 16'h0000;
      s_next.tsh = {1'b1, s_reg.tsh[10:1]};
      s_next.tcnt = s_reg.tcnt + 4'h1;
      if (s_reg.tcnt == 4'ha) begin
        s_next.tbusy = 1'b0;
      end
    end else begin
      s_next.tdiv = s_reg.tdiv + 16'h0001;
    end
    if (!s_reg.rbusy) begin
      if (!s_reg.sync[1]) begin
        s_next.rbusy = 1'b1;
        s_next.rcnt = 4'h0;
        s_next.rdiv = {1'b0, bit_cycles_i[15:1]};
      end
    end else if (s_reg.rdiv == 16'h0000) begin
      s_next.rdiv = bit_cycles_i - 16'h0001;
      s_next.rsh = {s_reg.sync[1], s_reg.rsh[9:1]};
      s_next.rcnt = s_reg.rcnt + 4'h1;
      if (s_reg.rcnt == 4'ha) begin
        s_next.rbusy = 1'b0;
        s_next.rvalid = 1'b1;
        s_next.rdata = s_reg.rsh[9:1];
      end
    end else begin
      s_next.rdiv = s_reg.rdiv - 16'h0001;
    end
  end
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      s_reg <= '0;
      s_reg.tsh <= '1;
      s_reg.sync <= 2'b11;
    end else begin
      s_reg <= s_next;
    end
  end
  assign link.far_tx = s_reg.tsh[0];
  assign busy_o = s_reg.tbusy;
  assign rx_valid_o = s_reg.rvalid;
  assign rx_data_o = s_reg.rdata;
endmodule

// ===== ubsa_chk.sv
`timescale 1ns/1ps
module ubsa_chk (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic dev_tx,
  input wire logic far_tx,
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic xtal_i,
  input wire logic low_power_o,
  input wire logic run_o,
  input wire logic tick_o
);
  import ubsa_pkg::*;
  typedef struct packed {
    logic [2:0] off;
  } ubsa_chk_st_t;
  ubsa_chk_st_t st_reg, st_next;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  // Clock-off age saturates late so the tick pipeline can drain
  always_comb begin
    st_next = st_reg;
    if (st_reg.off != 3'h0 && st_reg.off != 3'h7) begin
      st_next.off = st_reg.off + 3'h1;
    end
    if (wr_i && addr_i == ADDR_PSR) begin
      st_next.off = (wdata_i[7:3] == PSC_OFF) ? 3'h1 : 3'h0;
    end
  end
  always_ff @(posedge core_clk_i) begin
    if (reset_i) st_reg <= '{off: 3'h1};
    else st_reg <= st_next;
  end
  sequence s_wake;
    low_power_o && $fell(far_tx);
  endsequence
  sequence s_quiet;
    (low_power_o && far_tx) [*4];
  endsequence
  chk_tick_off: assert property (st_reg.off == 3'h7 |-> !tick_o)
    else $error("tick while clock off");
  chk_wake_start: assert property (s_wake |-> ##[1:8] !low_power_o)
    else $error("no wake on start bit");
  chk_sleep_holds: assert property (s_quiet |=> low_power_o)
    else $error("left sleep without start bit");
  chk_xtal_delay: assert property (
    $fell(low_power_o) && xtal_i |-> ##[250:262] $rose(run_o))
    else $error("crystal wake delay wrong");
  chk_fast_wake: assert property (
    $fell(low_power_o) && !xtal_i |-> ##[0:2] run_o)
    else $error("wake without crystal slow");
  chk_tx_quiet: assert property (
    low_power_o && $past(low_power_o) |-> dev_tx)
    else $error("serial out not high in sleep");
  chk_run_held: assert property (
    low_power_o && $past(low_power_o) |-> !run_o)
    else $error("engine runs in sleep");
  chk_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data outside its cycle");
  chk_link_idle: assert property ($fell(reset_i) |-> dev_tx && far_tx)
    else $error("link not idle after reset");
endmodule

// ===== uart_baud_sleep_attention_test.sv
`timescale 1ns/1ps
module uart_baud_sleep_attention_test;
  import ubsa_pkg::*;
  logic core_clk_i = 0, reset_i = 1, wr_i = 0, rd_i = 0, xtal_i = 0;
  logic send_i = 0, low_power_o, run_o, tick_o, busy_o, rx_valid_o;
  logic [3:0] addr_i = 0;
  logic [7:0] wdata_i = 0, rdata_o, d, e;
  logic [8:0] send_data_i = 0, rx_data_o;
  logic [15:0] bit_cycles_i = 16'h0010;
  logic x;
  int err_count = 0, num_checks = 0;
  logic [8:0] exp_q[$];
  ubsa_link_if ubsa_link_if_i ();
  ubsa_device_end ubsa_device_end_i (.core_clk_i, .reset_i,
    .link(ubsa_link_if_i), .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .xtal_i, .low_power_o, .run_o, .tick_o);
  ubsa_far_end ubsa_far_end_i (.core_clk_i, .reset_i,
    .link(ubsa_link_if_i), .bit_cycles_i, .send_i, .send_data_i,
    .busy_o, .rx_valid_o, .rx_data_o);
  ubsa_chk ubsa_chk_i (.core_clk_i, .reset_i,
    .dev_tx(ubsa_link_if_i.dev_tx), .far_tx(ubsa_link_if_i.far_tx),
    .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .xtal_i, .low_power_o,
    .run_o, .tick_o);
  initial forever #10 core_clk_i = ~core_clk_i;
  task automatic chk(string nm, logic [31:0] ev, logic [31:0] g);
    num_checks++;
    if (g !== ev) begin
      err_count++;
      $display("Error %s expected %0h seen %0h", nm, ev, g);
    end
  endtask
  task automatic wr(logic [3:0] a, logic [7:0] v);
    @(posedge core_clk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge core_clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rchk(string nm, logic [3:0] a, logic [7:0] ev,
                      logic [7:0] mk);
    @(posedge core_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge core_clk_i);
    rd_i <= 1'b0;
    #1 chk(nm, ev, rdata_o & mk);
  endtask
  task automatic wait_for(string nm, ref logic s, input logic v,
                          input int lim);
    int n = 0;
    while (s !== v && n < lim) begin
      @(negedge core_clk_i);
      n++;
    end
    chk(nm, v, s);
  endtask
  task automatic fsend(logic [8:0] v);
    @(posedge core_clk_i);
    send_i <= 1'b1;
    send_data_i <= v;
    @(posedge core_clk_i);
    send_i <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    wait_for("far busy", busy_o, 1'b0, 400);
    repeat (30) @(posedge core_clk_i);
  endtask
  // Two ticks span a whole floor/ceil pair, so the gap is exact
  task automatic gap(logic [4:0] c, logic [10:0] m);
    time t0;
    wr(ADDR_PSR, 8'h00);
    wr(ADDR_BAUD, m[7:0]);
    wr(ADDR_PSR, {c, m[10:8]});
    wait_for("tick", tick_o, 1'b1, 9000);
    t0 = $time;
    repeat (2) begin
      @(negedge core_clk_i);
      wait_for("tick", tick_o, 1'b1, 9000);
    end
    chk("tick gap", (m + 1) * (c + 1), ($time - t0) / 20);
  endtask
  task automatic wrap_up();
    $display("Checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(negedge core_clk_i) begin
    if (rx_valid_o === 1'b1 && exp_q.size() > 0) begin
      chk("far rx", exp_q.pop_front(), rx_data_o);
    end
  end
  initial begin
    repeat (60000) @(posedge core_clk_i);
    err_count++;
    wrap_up();
  end
  initial begin
    void'($urandom(32'h2b27f1f1));
    repeat (5) @(posedge core_clk_i);
    reset_i <= 1'b0;
    rchk("psr", ADDR_PSR, 8'h00, 8'hff);
    rchk("line", ADDR_LINE, 8'h20, 8'hff);
    wr(4'hf, 8'hff);
    rchk("unmapped", 4'hf, 8'h00, 8'hff);
    $display("Test done: reset");
    gap(5'h01, 11'h000);
    gap(5'h02, 11'h000);
    gap(5'h04, 11'h002);
    gap(5'h1f, 11'h003);
    gap(5'h01, 11'h100);
    gap(5'($urandom_range(31, 1)), 11'($urandom_range(15, 0)));
    wr(ADDR_PSR, 8'h00);
    wait_for("tick stop", tick_o, 1'b0, 8);
    repeat (100) @(negedge core_clk_i) chk("tick off", 0, tick_o);
    wr(ADDR_BAUD, 8'h00);
    wr(ADDR_PSR, 8'h08);
    $display("Test done: baud");
    // Second pass: sync mode, two stops; 30 cycles only fits factor two
    for (int s = 0; s < 2; s++) begin
      x = 1'($urandom);
      d = 8'($urandom);
      wr(ADDR_LINE, {3'h0, s[0], s[0], x, 2'b11});
      wr(ADDR_TXBUF, d);
      repeat (s ? 30 : 300) @(posedge core_clk_i);
      rchk("loop rxcs", ADDR_RXCS, {3'h0, 1'b1, x, 3'h0}, 8'h1f);
      rchk("loop data", ADDR_RXBUF, d, 8'hff);
    end
    // Let the far receiver finish the garbled sync-mode frame
    repeat (200) @(posedge core_clk_i);
    $display("Test done: loopback");
    wr(ADDR_LINE, {5'h00, x, 2'b10});
    repeat (2) begin
      d = 8'($urandom);
      exp_q.push_back({x, d});
      wr(ADDR_TXBUF, d);
    end
    for (int i = 0; i < 600 && exp_q.size() > 0; i++) @(posedge core_clk_i);
    chk("tx left", 0, exp_q.size());
    rchk("tx empty", ADDR_LINE, 8'h20, 8'h20);
    $display("Test done: transmit");
    d = 8'($urandom);
    e = 8'($urandom);
    wr(ADDR_RXCS, 8'h01);
    fsend({1'b0, d});
    rchk("hunt drop", ADDR_RXCS, 8'h01, 8'h11);
    fsend({1'b1, e});
    rchk("hunt addr", ADDR_RXCS, 8'h18, 8'h1f);
    rchk("hunt buf", ADDR_RXBUF, e, 8'hff);
    fsend({1'b0, d});
    fsend({1'b0, e});
    rchk("overrun", ADDR_RXCS, 8'h14, 8'h17);
    wr(ADDR_RXCS, 8'h80);
    rchk("err clear", ADDR_RXCS, 8'h10, 8'h16);
    rchk("drain", ADDR_RXBUF, e, 8'hff);
    fsend({1'b1, e});
    wr(ADDR_RXCS, 8'h01);
    $display("Test done: hunting");
    wr(ADDR_WAKE, 8'h08);
    for (int i = 0; i < 2; i++) begin
      xtal_i <= (i == 0);
      wr(ADDR_TXBUF, 8'h5a);
      wr(ADDR_TXBUF, 8'ha5);
      wr(ADDR_PWR, 8'h01);
      wait_for("sleep", low_power_o, 1'b1, 8);
      rchk("sleep line", ADDR_LINE, 8'h22, 8'h23);
      rchk("sleep rxcs", ADDR_RXCS, 8'h01, 8'h1f);
      rchk("sleep rxbuf", ADDR_RXBUF, e, 8'hff);
      rchk("sleep txbuf", ADDR_TXBUF, 8'ha5, 8'hff);
      fsend(9'h0f0);
      wait_for("awake", run_o, 1'b1, 300);
    end
    $display("Test done: low power");
    wrap_up();
  end
endmodule
